// file: irq_pkg.sv
// package of constants for the display interrupt aggregator and its service end
`default_nettype none
package irq_pkg;
	localparam int num_categories   = 4;
	localparam int srcs_per_cat     = 8;
	localparam int num_sources      = num_categories * srcs_per_cat;
	localparam int global_enable_bit = 31;
	localparam int ctl_width        = 32;
	localparam logic [31:0] ctl_reset = 32'h0000_0000;
	localparam logic [1:0] sel_status   = 2'h0;
	localparam logic [1:0] sel_mask     = 2'h1;
	localparam logic [1:0] sel_identity = 2'h2;
	localparam logic [1:0] sel_enable   = 2'h3;
endpackage
`default_nettype wire

// file: irq_link_if.sv
// interface joining the aggregator and the upstream service end
`default_nettype none
interface irq_link_if;
	logic                              ctl_wr;
	logic [31:0]                       ctl_wdata;
	logic [31:0]                       ctl_rdata;
	logic                              cat_rd;
	logic                              cat_wr;
	logic [1:0]                        cat_sel;
	logic [$clog2(irq_pkg::num_categories)-1:0] cat_idx;
	logic [irq_pkg::srcs_per_cat-1:0]  cat_wdata;
	logic [irq_pkg::srcs_per_cat-1:0]  cat_rdata;
	logic                              display_irq;
	modport device (input ctl_wr, ctl_wdata, cat_rd, cat_wr, cat_sel, cat_idx, cat_wdata,
		output ctl_rdata, cat_rdata, display_irq);
	modport host (output ctl_wr, ctl_wdata, cat_rd, cat_wr, cat_sel, cat_idx, cat_wdata,
		input ctl_rdata, cat_rdata, display_irq);
endinterface
`default_nettype wire

// file: display_interrupt_aggregator.sv
// device end: two-level display interrupt aggregation
// Summary of operation
// RQ1 - live status bit follows raw event
// RQ2 - unmasked interrupt is event and not mask
// RQ3 - unmasked rising edge sets identity bit
// RQ4 - write one clears identity, zero keeps
// RQ5 - identity queues two events, resets after clear
// RQ6 - enabled interrupt is identity and enable
// RQ7 - category pending is OR of enabled
// RQ8 - combined interrupt is OR of categories
// RQ9 - bit 31 gates combined interrupt
// RQ10 - enabled interrupt goes to upstream logic
// RQ11 - service reads then clears upstream indication
// RQ12 - service clears bit 31 before re-enable
// RQ13 - service reads pending, identity, writes ones
// RQ14 - service may repeat identity clears
// RQ15 - setting bit 31 re-asserts if pending
// RQ16 - optional re-read loop before re-enable
// RQ17 - do not trust live status pulses
// RQ18 - outgoing interrupt is a level
`default_nettype none
module display_interrupt_aggregator
(
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic [irq_pkg::num_sources-1:0] raw_event,
	irq_link_if.device                          link
);
	localparam int n = irq_pkg::num_sources;
	localparam int w = irq_pkg::srcs_per_cat;

	logic [n-1:0]  mask_r;
	logic [n-1:0]  mask_nxt;
	logic [n-1:0]  enable_r;
	logic [n-1:0]  enable_nxt;
	logic [n-1:0]  ident_r;
	logic [n-1:0]  ident_nxt;
	logic [n-1:0]  queued_r;
	logic [n-1:0]  queued_nxt;
	logic [n-1:0]  unmasked_prev_r;
	logic [n-1:0]  status_r;
	logic          gate_r;
	logic          gate_nxt;
	logic [31:0]   rdata_r;
	logic [31:0]   rdata_nxt;
	logic [w-1:0]  cat_rdata_r;
	logic [w-1:0]  cat_rdata_nxt;
	logic          irq_r;
	logic          irq_nxt;

	wire  [n-1:0]  unmasked  = raw_event & ~mask_r; // RQ2
	wire  [n-1:0]  rise      = unmasked & ~unmasked_prev_r; // RQ3
	wire  [n-1:0]  enabled   = ident_r & enable_r; // RQ6
	wire  [n-1:0]  sel_bits  = {{(n-w){1'b0}}, link.cat_wdata} << (link.cat_idx * w);
	wire  [n-1:0]  sel_field = {{(n-w){1'b0}}, {w{1'b1}}} << (link.cat_idx * w);
	wire           wr_mask   = link.cat_wr && link.cat_sel == irq_pkg::sel_mask;
	wire           wr_enable = link.cat_wr && link.cat_sel == irq_pkg::sel_enable;
	wire           wr_ident  = link.cat_wr && link.cat_sel == irq_pkg::sel_identity;
	wire  [n-1:0]  clear     = wr_ident ? sel_bits : {n{1'b0}}; // RQ4
	wire  [n-1:0]  taken     = clear & ident_r;
	wire  [n-1:0]  held      = queued_r | (rise & ident_r);
	logic [irq_pkg::num_categories-1:0] pending;
	wire           combined  = |pending; // RQ8

	function automatic logic [w-1:0] field(input logic [n-1:0] v, input int idx);
		field = v[idx*w +: w];
	endfunction

	always_comb
	begin
		for (int c = 0; c < irq_pkg::num_categories; c++)
			pending[c] = |field(enabled, c); // RQ7
	end

	always_comb
	begin
		mask_nxt   = wr_mask ? ((mask_r & ~sel_field) | sel_bits) : mask_r;
		enable_nxt = wr_enable ? ((enable_r & ~sel_field) | sel_bits) : enable_r;
		// a clear of a bit with a second queued event refills it; a new edge always wins
		ident_nxt  = (ident_r & ~clear) | (clear & queued_r) | rise; // RQ5
		// clear and edge together on a full queue keep two events held
		queued_nxt = (~taken & held) | (taken & queued_r & rise); // RQ5
		unique case (link.cat_sel)
			irq_pkg::sel_status:   cat_rdata_nxt = field(status_r, int'(link.cat_idx)); // RQ1
			irq_pkg::sel_mask:     cat_rdata_nxt = field(mask_r, int'(link.cat_idx));
			irq_pkg::sel_identity: cat_rdata_nxt = field(ident_r, int'(link.cat_idx));
			irq_pkg::sel_enable:   cat_rdata_nxt = field(enable_r, int'(link.cat_idx));
		endcase
	end

	assign gate_nxt  = link.ctl_wr ? link.ctl_wdata[irq_pkg::global_enable_bit] : gate_r; // RQ12
	assign rdata_nxt = {gate_r, {(31-irq_pkg::num_categories){1'b0}}, pending}; // RQ7
	// level: drops with bit 31 and rises again while anything stays set
	assign irq_nxt   = combined && gate_r; // RQ9 RQ15 RQ18

	// masked after reset so no stale edge lands before the host sets up
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mask_r <= {n{1'b1}};
		end
		else
		begin
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			enable_r <= {n{1'b0}};
		end
		else
		begin
			enable_r <= enable_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ident_r <= {n{1'b0}};
		end
		else
		begin
			ident_r <= ident_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			queued_r <= {n{1'b0}};
		end
		else
		begin
			queued_r <= queued_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			unmasked_prev_r <= {n{1'b0}};
		end
		else
		begin
			unmasked_prev_r <= unmasked;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status_r <= {n{1'b0}};
		end
		else
		begin
			status_r <= raw_event; // RQ1
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gate_r <= 1'b0;
		end
		else
		begin
			gate_r <= gate_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_r <= irq_pkg::ctl_reset;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cat_rdata_r <= {w{1'b0}};
		end
		else if (link.cat_rd)
		begin
			cat_rdata_r <= cat_rdata_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_r <= 1'b0;
		end
		else
		begin
			irq_r <= irq_nxt;
		end
	end

	assign link.ctl_rdata   = rdata_r;
	assign link.cat_rdata   = cat_rdata_r;
	assign link.display_irq = irq_r; // RQ10
endmodule
`default_nettype wire

// file: interrupt_service_end.sv
// host end: upstream primary indication and service sequencer
`default_nettype none
module interrupt_service_end
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        primary_clear,
	output logic             primary_pending,
	output logic             service_busy,
	output logic [irq_pkg::srcs_per_cat-1:0] serviced_bits,
	output logic             serviced_valid,
	output logic [1:0]       serviced_cat,
	irq_link_if.host         link
);
	typedef enum {setup_mask, setup_enable, idle, disable_gate, read_ctl, wait_ctl, read_id,
		wait_id, clear_id, enable_gate} state_type;
	state_type state_r;
	state_type state_nxt;
	logic      irq_prev_r;
	logic      pend_r;
	logic [irq_pkg::num_categories-1:0] cats_r;
	logic [1:0] cat_r;
	logic [irq_pkg::srcs_per_cat-1:0] bits_r;
	logic       valid_r;
	logic [1:0] done_cat_r;

	wire rise = link.display_irq && !irq_prev_r;
	wire cat_hit = cats_r[cat_r];
	// masks opened and enables set once after reset, then the gate is opened
	wire setup    = state_r == setup_mask || state_r == setup_enable;
	wire step_cat = (state_r == read_id && !cat_hit) || state_r == clear_id || setup;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			setup_mask:   state_nxt = (cat_r == 2'h3) ? setup_enable : setup_mask;
			setup_enable: state_nxt = (cat_r == 2'h3) ? enable_gate : setup_enable;
			idle:         if (pend_r) state_nxt = disable_gate; // RQ11
			disable_gate: state_nxt = read_ctl; // RQ12
			read_ctl:     state_nxt = wait_ctl;
			wait_ctl:     state_nxt = read_id; // RQ13
			read_id:      state_nxt = cat_hit ? wait_id : (cat_r == 2'h3 ? enable_gate : read_id);
			wait_id:      state_nxt = clear_id;
			// no re-read loop: late events re-enter once the gate reopens
			clear_id:     state_nxt = (cat_r == 2'h3) ? enable_gate : read_id; // RQ14 RQ16
			enable_gate:  state_nxt = idle; // RQ15
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= setup_mask;
			done_cat_r <= 2'h0;
			irq_prev_r <= 1'b0;
			pend_r <= 1'b0;
			cats_r <= '0;
			cat_r <= 2'h0;
			bits_r <= '0;
			valid_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			irq_prev_r <= link.display_irq;
			pend_r <= rise | (pend_r & ~(state_r == idle) & ~primary_clear); // RQ11
			valid_r <= state_r == clear_id;
			if (state_r == wait_ctl)
			begin
				cats_r <= link.ctl_rdata[irq_pkg::num_categories-1:0];
				cat_r <= 2'h0;
			end
			if (state_r == wait_id)
				bits_r <= link.cat_rdata;
			if (state_r == clear_id)
				done_cat_r <= cat_r;
			if (step_cat)
				cat_r <= cat_r + 2'h1;
		end
	end

	assign link.ctl_wr    = state_r == disable_gate || state_r == enable_gate;
	assign link.ctl_wdata = {state_r == enable_gate, 31'h0000_0000};
	assign link.cat_rd    = state_r == read_id && cat_hit;
	assign link.cat_wr    = state_r == clear_id || setup;
	// live status never read: pulse events are gone too soon
	assign link.cat_sel   = (state_r == setup_mask) ? irq_pkg::sel_mask :
		(state_r == setup_enable) ? irq_pkg::sel_enable : irq_pkg::sel_identity; // RQ17
	assign link.cat_idx   = cat_r;
	assign link.cat_wdata = (state_r == setup_mask) ? {irq_pkg::srcs_per_cat{1'b0}} :
		(state_r == setup_enable) ? {irq_pkg::srcs_per_cat{1'b1}} : link.cat_rdata; // RQ13
	assign primary_pending = pend_r;
	assign service_busy   = state_r != idle;
	assign serviced_bits  = bits_r;
	assign serviced_valid = valid_r;
	assign serviced_cat   = done_cat_r;
endmodule
`default_nettype wire

// file: irq_link_assertions.sv
// checker for the link between aggregator and service end
`default_nettype none
module irq_link_assertions
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ctl_wr,
	input wire logic [31:0] ctl_wdata,
	input wire logic [31:0] ctl_rdata,
	input wire logic        cat_rd,
	input wire logic        cat_wr,
	input wire logic [1:0]  cat_sel,
	input wire logic [7:0]  cat_wdata,
	input wire logic [7:0]  cat_rdata,
	input wire logic        display_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic id_wr = cat_wr && cat_sel == irq_pkg::sel_identity;
	sequence gate_off;
		ctl_wr && !ctl_wdata[31];
	endsequence
	sequence quiet2;
		(!ctl_wr && !cat_wr)[*2];
	endsequence
	chk_irq_matches_ctl: assert property (display_irq == (ctl_rdata[31] && |ctl_rdata[3:0]))
		else $error("irq differs from control read");
	chk_irq_level_holds: assert property (quiet2 ##0 display_irq |=> display_irq)
		else $error("irq dropped with no write");
	chk_gate_off_drops: assert property (gate_off |-> ##2 !display_irq)
		else $error("irq stays after gate clear");
	chk_host_clears_gate: assert property ($rose(display_irq) |-> ##[1:400] gate_off)
		else $error("gate not cleared in service");
	chk_reenable_idle: assert property (ctl_wr && ctl_wdata[31] |-> !display_irq)
		else $error("gate set while irq high");
	chk_writeback_read: assert property (id_wr |-> cat_wdata == cat_rdata)
		else $error("identity write differs from read");
	chk_read_holds: assert property (!cat_rd |=> $stable(cat_rdata))
		else $error("read data moved");
	chk_reset_quiet: assert property ($fell(rst) |-> !display_irq && ctl_rdata == irq_pkg::ctl_reset)
		else $error("not idle after reset");
endmodule
`default_nettype wire

// file: display_interrupt_aggregator_tb.sv
// self-checking bench joining aggregator and service end
`default_nettype none
module display_interrupt_aggregator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        primary_clear = 1'b0;
	logic        seen_pend = 1'b0;
	logic [31:0] raw_event = 32'h0;
	logic        primary_pending;
	logic        serviced_valid;
	logic [7:0]  serviced_bits;
	logic [1:0]  serviced_cat;
	int          bad_count = 0;
	int          check_count = 0;
	irq_link_if  link ();
	always #10 clk = ~clk;
	// upstream answers its own pending flag, as service software would
	always @(posedge clk)
	begin
		primary_clear <= primary_pending;
		if (primary_pending === 1'b1)
			seen_pend <= 1'b1;
	end
	display_interrupt_aggregator i_display_interrupt_aggregator
	(.clk(clk), .rst(rst), .raw_event(raw_event), .link(link));
	interrupt_service_end i_interrupt_service_end
	(.clk(clk), .rst(rst), .primary_clear(primary_clear), .primary_pending(primary_pending),
		.service_busy(), .serviced_bits(serviced_bits), .serviced_valid(serviced_valid),
		.serviced_cat(serviced_cat), .link(link));
	irq_link_assertions i_irq_link_assertions
	(.clk(clk), .rst(rst), .ctl_wr(link.ctl_wr), .ctl_wdata(link.ctl_wdata),
		.ctl_rdata(link.ctl_rdata), .cat_rd(link.cat_rd), .cat_wr(link.cat_wr),
		.cat_sel(link.cat_sel), .cat_wdata(link.cat_wdata), .cat_rdata(link.cat_rdata),
		.display_irq(link.display_irq));
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task automatic pulse(input logic [31:0] bits);
		@(posedge clk) raw_event <= bits;
		repeat (2) @(posedge clk);
		raw_event <= 32'h0;
		repeat (2) @(posedge clk);
	endtask
	// samples 2 ns after the edge so the edge's updates have landed
	task automatic wait_svc(input int lim, output logic got);
		got = 1'b0;
		for (int n = 0; n < lim && !got; n++)
		begin
			@(posedge clk);
			#2;
			got = serviced_valid === 1'b1;
		end
	endtask
	task automatic expect_svc(input logic [1:0] cat, input logic [7:0] bits);
		logic got;
		wait_svc(2000, got);
		check(got && serviced_cat === cat && serviced_bits === bits, "wrong service");
		if (!got)
			print_verdict();
	endtask
	initial
	begin
		logic got;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (40) @(posedge clk);
		for (int c = 0; c < 4; c++)
		begin
			pulse(32'h1 << (c * 9));
			expect_svc(c[1:0], 8'h01 << c);
		end
		pulse(32'h0000_0021);
		expect_svc(2'h0, 8'h21);
		pulse(32'h0000_0200);
		pulse(32'h0000_0200);
		expect_svc(2'h1, 8'h02);
		expect_svc(2'h1, 8'h02);
		@(posedge clk) raw_event <= 32'h8000_0000;
		expect_svc(2'h3, 8'h80);
		wait_svc(300, got);
		check(!got, "level event fired twice");
		check(seen_pend, "no upstream indication");
		print_verdict();
	end
endmodule
`default_nettype wire
